// *** core/frame_sequencer.sv ***
// Purpose: transmit/receive sequencer for flag-delimited frames on a shared line
// Assumes: controller core on sys_clk; bit clock from the rate generator on a pin
// Notes: one frame in the rx buffer at a time, freed by rx_release
// How it works
// - flag time is measured by our own bit timer, controller gives no sign
// - controller sends last byte, two crc, a flag, 12..18 bits marking
// - controller delivers address and both crc bytes unfiltered
// - end-of-frame event comes after both crc bytes were delivered
// - the transmit shifter delays bytes by three bits
// - line runs 230.4 kbit/s, bit clock is 3.6864 MHz divided by 16
// - driver enable is a control bit that tri-states the line driver
// - with address search on, foreign-address frames are dropped
`timescale 1ns/1ps
`default_nettype none
module frame_sequencer
    import frame_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    // frame bytes from the source, last byte marked
    input wire logic src_valid,
    output logic src_ready,
    input wire logic [BYTE_W-1:0] src_data,
    input wire logic src_last,
    input wire logic tx_start,
    output logic tx_busy,
    // serial controller core
    input wire logic bit_clk,
    input wire logic tx_buf_empty,
    output logic [BYTE_W-1:0] tx_data,
    output logic tx_write,
    output logic mark_on_idle,
    output logic line_en_n,
    input wire logic rx_valid,
    input wire logic [BYTE_W-1:0] rx_data,
    input wire logic rx_eof,
    input wire logic rx_overrun,
    input wire logic rx_crc_err,
    // receive buffer and reply timing
    input wire logic reply_owed,
    input wire logic rx_release,
    input wire logic [RX_AW-1:0] rd_addr,
    output logic [BYTE_W-1:0] rd_data,
    output logic rx_ready,
    output logic rx_err,
    output logic [RX_AW-1:0] rx_len
);
    // ****************************************
    // tx fifo
    // ****************************************
    logic f_valid, f_ready;
    logic [BYTE_W:0] f_data;
    byte_fifo #(.WIDTH(BYTE_W + 1), .DEPTH(TX_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .in_data({src_last, src_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // ****************************************
    // bit timer
    // ****************************************
    logic bclk_s1_q, bclk_s2_q, bclk_s3_q, bit_edge;
    logic tmr_flag_q, tmr_load;
    logic [7:0] tmr_cnt_q, tmr_val;
    // bit clock from the rate generator pin, two flops then edge detect
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end else begin
            bclk_s1_q <= bit_clk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
        end
    end
    assign bit_edge = bclk_s2_q && !bclk_s3_q;

    // down counter on bit edges, sticky expiry flag
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tmr_cnt_q <= 8'h00;
            tmr_flag_q <= 1'b0;
        end else if (tmr_load) begin
            tmr_cnt_q <= tmr_val;
            tmr_flag_q <= 1'b0;
        end else if (bit_edge && tmr_cnt_q != 8'h00) begin
            tmr_cnt_q <= tmr_cnt_q - 8'h01;
            if (tmr_cnt_q == 8'h01) begin
                tmr_flag_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // transmit sequence
    // ****************************************
    tx_state_t st_q;
    logic [7:0] sync_cnt_q;
    logic reply_go_q, go;
    assign go = (tx_start || reply_go_q) && f_valid;
    assign tmr_load = (st_q == ST_SYNC && sync_cnt_q == 8'h01) || (st_q == ST_QUIET && tmr_flag_q)
        || (f_ready && f_data[BYTE_W]); // tail counts from the pop of the last byte
    assign tmr_val = st_q == ST_SYNC ? SILENCE_EDGES : st_q == ST_QUIET ? FLAG_EDGES : TAIL_EDGES;
    // pop a byte once flags ran out, then on each empty buffer
    assign f_ready = !tx_write && f_valid && ((st_q == ST_FLAGS && tmr_flag_q)
        || (st_q == ST_DATA && tx_buf_empty));

    // state walk
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            sync_cnt_q <= 8'h00;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (go) begin
                        st_q <= ST_SYNC;
                        sync_cnt_q <= SYNC_CYC_W;
                    end
                end
                ST_SYNC: begin
                    sync_cnt_q <= sync_cnt_q - 8'h01;
                    if (sync_cnt_q == 8'h01) begin
                        st_q <= ST_QUIET;
                    end
                end
                ST_QUIET: if (tmr_flag_q) st_q <= ST_FLAGS;
                ST_FLAGS: if (f_ready) st_q <= f_data[BYTE_W] ? ST_TAIL : ST_DATA;
                ST_DATA: if (f_ready && f_data[BYTE_W]) st_q <= ST_TAIL;
                ST_TAIL: if (tmr_flag_q && !tmr_load) st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // byte handoff to the controller; source owns the address bytes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_write <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            tx_write <= f_ready;
            if (f_ready) begin
                tx_data <= f_data[BYTE_W-1:0];
            end
        end
    end

    // driver enable: pulse, silence, then held low through the tail
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            line_en_n <= 1'b1;
            tx_busy <= 1'b0;
        end else begin
            line_en_n <= !((st_q == ST_IDLE && go) || (st_q == ST_SYNC && sync_cnt_q != 8'h01)
                || (st_q == ST_QUIET && tmr_flag_q) || st_q == ST_FLAGS || st_q == ST_DATA
                || (st_q == ST_TAIL && !(tmr_flag_q && !tmr_load)));
            tx_busy <= st_q != ST_IDLE || go;
        end
    end

    // mark on idle from the first write until the frame ends
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mark_on_idle <= 1'b0;
        end else if (st_q == ST_IDLE) begin
            mark_on_idle <= 1'b0;
        end else if (tx_write) begin
            mark_on_idle <= 1'b1;
        end
    end

    // ****************************************
    // receive buffer
    // ****************************************
    logic [BYTE_W-1:0] rx_mem [2**RX_AW];
    logic [RX_AW-1:0] wr_ptr_q;
    logic [10:0] reply_cnt_q;
    logic too_long_q, take;
    assign take = rx_valid && !rx_ready && wr_ptr_q < RX_MAX_LEN; // address filter sits upstream
    always_ff @(posedge sys_clk) begin
        if (take) begin
            rx_mem[wr_ptr_q] <= rx_data;
        end
        rd_data <= rx_mem[rd_addr];
    end

    // pointer, length check, end of frame
    always_ff @(posedge sys_clk) begin
        if (reset || rx_release) begin
            wr_ptr_q <= '0;
            too_long_q <= 1'b0;
            rx_ready <= 1'b0;
            rx_err <= 1'b0;
            rx_len <= '0;
        end else if (rx_eof && !rx_ready) begin
            wr_ptr_q <= wr_ptr_q < CRC_BYTES ? '0 : wr_ptr_q - CRC_BYTES;
            rx_len <= wr_ptr_q < CRC_BYTES ? '0 : wr_ptr_q - CRC_BYTES;
            rx_ready <= 1'b1;
            rx_err <= rx_overrun || rx_crc_err || too_long_q;
        end else if (rx_valid && !rx_ready) begin
            if (take) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end else begin
                too_long_q <= 1'b1;
            end
        end
    end

    // reply start timer from end of frame
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reply_cnt_q <= '0;
            reply_go_q <= 1'b0;
        end else begin
            if (rx_eof && !rx_ready && reply_owed) begin
                reply_cnt_q <= REPLY_CYC_W;
            end else if (reply_cnt_q != '0) begin
                reply_cnt_q <= reply_cnt_q - 1'b1;
            end
            if (reply_cnt_q == 11'h001) begin
                reply_go_q <= 1'b1;
            end else if (st_q != ST_IDLE || !f_valid) begin
                reply_go_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [15:0] quiet_cyc_q, on_cyc_q, tail_cyc_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            quiet_cyc_q <= '0;
            on_cyc_q <= '0;
            tail_cyc_q <= '0;
        end else begin
            quiet_cyc_q <= st_q == ST_QUIET ? quiet_cyc_q + 16'h0001 : 16'h0000;
            on_cyc_q <= st_q == ST_FLAGS ? on_cyc_q + 16'h0001 : 16'h0000;
            tail_cyc_q <= st_q == ST_TAIL ? tail_cyc_q + 16'h0001 : 16'h0000;
        end
    end
    sequence s_pulse;
        !line_en_n [*6] ##1 line_en_n;
    endsequence
    a_sync_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_IDLE && go |=> s_pulse) else $error("sync pulse shape wrong");
    a_quiet_bit: assert property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_QUIET && tmr_flag_q |-> quiet_cyc_q >= 16'(BIT_CYC - 1)) else $error("silence short");
    a_quiet_three: assert property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_QUIET |-> line_en_n ##0 (!tmr_flag_q || quiet_cyc_q >= 16'((QUIET_MIN_BITS - 1) * BIT_CYC)))
        else $error("drivers on too soon");
    a_flag_wait: assert property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_FLAGS && f_ready |-> on_cyc_q >= 16'((LEAD_BITS - 1) * BIT_CYC)) else $error("flags cut");
    a_write_empty: assert property (@(posedge sys_clk) disable iff (reset)
        tx_write && $past(st_q) == ST_DATA |-> $past(tx_buf_empty)) else $error("write to full buffer");
    a_mark_tail: assert property (@(posedge sys_clk) disable iff (reset)
        st_q == ST_TAIL && !tx_write |-> mark_on_idle) else $error("no mark on idle in tail");
    a_tail_wait: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(line_en_n) && $past(st_q) == ST_TAIL |-> tail_cyc_q >= 16'((TAIL_MIN_BITS - 1) * BIT_CYC))
        else $error("tail too short");
    a_timer_fire: assert property (@(posedge sys_clk) disable iff (reset)
        !tmr_load && bit_edge && tmr_cnt_q == 8'h01 |=> tmr_flag_q && tmr_cnt_q == 8'h00)
        else $error("timer expiry lost");
    a_rx_rewind: assert property (@(posedge sys_clk) disable iff (reset)
        rx_eof && !rx_ready && !rx_release && wr_ptr_q >= CRC_BYTES |=> wr_ptr_q == $past(wr_ptr_q) - CRC_BYTES)
        else $error("pointer not moved back");
    a_rx_store: assert property (@(posedge sys_clk) disable iff (reset)
        take && !rx_eof && !rx_release |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1 && wr_ptr_q <= RX_MAX_LEN)
        else $error("store pointer wrong");
    a_rx_error: assert property (@(posedge sys_clk) disable iff (reset)
        rx_eof && !rx_ready && !rx_release && (rx_overrun || rx_crc_err) |=> rx_err && rx_ready)
        else $error("frame error missed");
    a_drv_held: assert property (@(posedge sys_clk) disable iff (reset)
        $past(st_q) == ST_FLAGS || $past(st_q) == ST_DATA |-> !line_en_n) else $error("driver gap");
endmodule : frame_sequencer
`default_nettype wire

// *** common/frame_seq_pkg.sv ***
// Purpose: shared constants for the frame sequencer and its tx byte fifo
// Assumes: sys_clk at 20 MHz; bit clock of 230.4 kHz arrives on a pin
// Notes: times are given in ns, cycle counts are derived from them
package frame_seq_pkg;
    // ****************************************
    // clock and bit timing
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int BIT_NS = 4300;                            // one bit interval, 4.3 us
    localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS; // least time, rounded up
    localparam int SYNC_NS = 300;                            // width of the enable pulse
    localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
    localparam int REPLY_NS = 70000;                         // reply start after end of frame
    localparam int REPLY_CYC = REPLY_NS / CLK_NS;
    // ****************************************
    // counts in bit-clock edges and in whole bits
    // ****************************************
    localparam logic [7:0] SILENCE_EDGES = 8'h04;  // one bit plus two more, edge-count slack
    localparam logic [7:0] FLAG_EDGES = 8'h11;     // 16 full intervals of leading flags
    localparam logic [7:0] TAIL_EDGES = 8'h2d;     // 44..50 interval tail, lands at 44..45
    localparam int LEAD_BITS = 16;
    localparam int TAIL_MIN_BITS = 44;
    localparam int QUIET_MIN_BITS = 3;
    // ****************************************
    // buffers and fixed-width cycle counts
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int TX_FIFO_DEPTH = 32;
    localparam int RX_AW = 10;
    localparam logic [RX_AW-1:0] RX_MAX_LEN = 10'h25d;       // 603 frame bytes plus 2 crc
    localparam logic [RX_AW-1:0] CRC_BYTES = 10'h002;
    localparam logic [10:0] REPLY_CYC_W = 11'h578;           // equals REPLY_CYC
    localparam logic [7:0] SYNC_CYC_W = 8'h06;               // equals SYNC_CYC
    // ****************************************
    // transmit sequence states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_QUIET = 3'b010,
        ST_FLAGS = 3'b011,
        ST_DATA = 3'b100,
        ST_TAIL = 3'b101
    } tx_state_t;
endpackage : frame_seq_pkg

// *** core/byte_fifo.sv ***
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: honest full and empty via an extra pointer bit
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    // ****************************************
    // pointers and storage
    // ****************************************
    assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];

    // write side
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_q <= '0;
        end else if (in_valid && in_ready) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (in_valid && in_ready) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // read side
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_q <= '0;
        end else if (out_valid && out_ready) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// *** sim/ctrl_model.sv ***
// Purpose: serial controller side model, bit clock and tx buffer
// Assumes: rate generator runs free, phase unrelated to sys_clk
// Notes: slow mode empties the buffer only after one byte time
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
    import frame_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic tx_write,
    input wire logic slow,
    output logic bit_clk,
    output logic tx_buf_empty
);
    int hold;
    // ****************
    // bit clock from the rate generator
    // ****************
    initial begin
        bit_clk = 1'b0;
        #777;
        forever #(BIT_NS / 2) bit_clk = ~bit_clk;
    end
    // buffer frees when the byte moves into the shifter
    initial tx_buf_empty = 1'b1;
    always @(posedge sys_clk) begin
        if (reset) begin
            hold = 0;
        end else if (tx_write) begin
            hold = slow ? 8 * BIT_CYC : 3;
        end else if (hold > 0) begin
            hold = hold - 1;
        end
        tx_buf_empty <= (hold == 0);
    end
endmodule : ctrl_model
`default_nettype wire

// *** sim/frame_sequencer_tb.sv ***
// Purpose: self-checking bench for the frame sequencer
// Assumes: sys_clk 20 MHz, bit clock from ctrl_model
// Notes: tx bytes and rx results are noted in queues and popped by monitors
`timescale 1ns/1ps
`default_nettype none
module frame_sequencer_tb
    import frame_seq_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic src_valid, src_ready, src_last, tx_start, tx_busy, bit_clk, tx_buf_empty;
    logic tx_write, mark_on_idle, line_en_n, rx_valid, rx_eof, rx_overrun, rx_crc_err;
    logic reply_owed, rx_release, rx_ready, rx_err, slow;
    logic [BYTE_W-1:0] src_data, tx_data, rx_data, rd_data;
    logic [RX_AW-1:0] rd_addr, rx_len;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int phase = 0;
    bit first = 1'b1;
    bit en_q = 1'b1;
    bit empty_q, rdy_q, reply_chk;
    longint t_a, t_b, t_w, t_eof;
    logic [7:0] tx_q[$];
    logic [7:0] rx_mem[0:1023];
    logic [RX_AW-1:0] len_q[$];
    logic err_q[$];

    frame_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .src_valid(src_valid), .src_ready(src_ready),
        .src_data(src_data), .src_last(src_last), .tx_start(tx_start), .tx_busy(tx_busy), .bit_clk(bit_clk),
        .tx_buf_empty(tx_buf_empty), .tx_data(tx_data), .tx_write(tx_write), .mark_on_idle(mark_on_idle),
        .line_en_n(line_en_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
        .rx_overrun(rx_overrun), .rx_crc_err(rx_crc_err), .reply_owed(reply_owed), .rx_release(rx_release),
        .rd_addr(rd_addr), .rd_data(rd_data), .rx_ready(rx_ready), .rx_err(rx_err), .rx_len(rx_len));
    ctrl_model peer_u (.sys_clk(sys_clk), .reset(reset), .tx_write(tx_write), .slow(slow),
        .bit_clk(bit_clk), .tx_buf_empty(tx_buf_empty));

    always #(CLK_NS / 2) sys_clk = ~sys_clk;

    // ****************
    // compare and report
    // ****************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_rng(input longint v, input longint lo, input longint hi);
        n_compared++;
        if (v < lo || v > hi) begin
            err_count++;
            $display("Error at %0t ns: %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask : chk_rng
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // ****************
    // drivers
    // ****************
    task automatic load(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            tx_q.push_back(d);
            src_valid <= 1'b1;
            src_data <= d;
            src_last <= (i == n - 1);
            do @(posedge sys_clk); while (src_ready !== 1'b1);
        end
        src_valid <= 1'b0;
    endtask : load
    task automatic wait_frame();
        int k;
        k = 0;
        while (tx_busy !== 1'b1 && k < 3000) begin
            @(posedge sys_clk);
            k++;
        end
        while (tx_busy !== 1'b0 && k < 30000) begin
            @(posedge sys_clk);
            k++;
        end
        chk_val(32'(tx_q.size()), 0);
        chk_val(32'(tx_busy), 0);
    endtask : wait_frame
    task automatic tx_go();
        @(posedge sys_clk);
        tx_start <= 1'b1;
        @(posedge sys_clk);
        tx_start <= 1'b0;
        wait_frame();
    endtask : tx_go
    task automatic rx_frame(input int n, input bit ovr, input bit crc, input bit owed);
        int m;
        logic [7:0] d;
        m = (n > 605) ? 605 : n;
        len_q.push_back(RX_AW'(m - 2));
        err_q.push_back(ovr | crc | (n > 605));
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            d = 8'($urandom);
            rx_mem[i] = d;
            rx_valid <= 1'b1;
            rx_data <= d;
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b1;
        rx_overrun <= ovr;
        rx_crc_err <= crc;
        reply_owed <= owed;
        @(posedge sys_clk);
        t_eof = $time;
        reply_chk = owed;
        rx_eof <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int k = 0; k < 3; k++) begin
            rd_addr <= RX_AW'((k == 2) ? m - 3 : k);
            @(posedge sys_clk);
            #1 chk_val(32'(rd_data), 32'(rx_mem[(k == 2) ? m - 3 : k]));
            @(posedge sys_clk);
        end
        rx_release <= 1'b1;
        @(posedge sys_clk);
        rx_release <= 1'b0;
    endtask : rx_frame
    // ****************
    // monitors
    // ****************
    // line enable timing and written bytes
    always @(posedge sys_clk) begin
        if (reset === 1'b1) begin
            phase = 0;
            first = 1'b1;
        end else begin
            if (line_en_n === 1'b0 && en_q) begin
                if (phase == 0) begin
                    if (reply_chk) chk_rng(($time - t_eof) / CLK_NS, 1399, 1405);
                    reply_chk = 1'b0;
                    t_a = $time;
                    phase = 1;
                end else begin
                    chk_rng($time - t_b, 3 * BIT_NS, 9 * BIT_NS);
                    t_a = $time;
                    phase = 2;
                    first = 1'b1;
                end
            end
            if (line_en_n === 1'b1 && !en_q) begin
                if (phase == 1) begin
                    chk_val(32'($time - t_a), SYNC_CYC * CLK_NS);
                    t_b = $time;
                end else if (phase == 2) begin
                    chk_rng($time - t_w, 44 * BIT_NS, 50 * BIT_NS);
                    chk_val(32'(tx_q.size()), 0);
                    phase = 0;
                end
            end
            if (tx_write === 1'b1) begin
                if (first) chk_rng($time - t_a, 16 * BIT_NS, 19 * BIT_NS);
                else chk_val(32'(mark_on_idle), 1);
                chk_val(32'(empty_q), 1);
                chk_val(32'(tx_data), 32'(tx_q.pop_front()));
                first = 1'b0;
                t_w = $time;
            end
        end
        en_q = (line_en_n !== 1'b0);
        empty_q = (tx_buf_empty === 1'b1);
    end
    // stored frame length and error flag
    always @(posedge sys_clk) begin
        if (rx_ready === 1'b1 && !rdy_q && len_q.size() > 0) begin
            chk_val(32'(rx_len), 32'(len_q.pop_front()));
            chk_val(32'(rx_err), 32'(err_q.pop_front()));
        end
        rdy_q = (rx_ready === 1'b1);
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            $display("Error at %0t ns: run timed out", $time);
            conclude();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(32'h40902de7));
        {src_valid, src_last, tx_start, rx_valid, rx_eof, rx_overrun} = '0;
        {rx_crc_err, reply_owed, rx_release, slow} = '0;
        {src_data, rx_data, rd_addr} = '0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        chk_val(32'({line_en_n, tx_busy, tx_write, mark_on_idle, rx_ready, rx_err, src_ready}), 32'h41);
        chk_val(32'(rx_len), 0);
        @(posedge sys_clk);
        load(TX_FIFO_DEPTH);
        #1 chk_val(32'(src_ready), 0);
        tx_go();
        slow <= 1'b1;
        load(2);
        tx_go();
        load(1);
        tx_go();
        slow <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rx_frame(3 + $urandom_range(0, 60), k[0], k[1], 1'b0);
        end
        rx_frame(606, 1'b0, 1'b0, 1'b0);
        load(3);
        rx_frame(8, 1'b0, 1'b0, 1'b1);
        wait_frame();
        repeat (4) @(posedge sys_clk);
        conclude();
    end
endmodule : frame_sequencer_tb
`default_nettype wire
